// File: core/tks_defs.svh
/*
  Offsets, field positions and reset values of the touch key sequencer.
  Assumes a 32-bit AXI4-Lite register window with byte addresses.
*/
`ifndef TKS_DEFS_SVH
`define TKS_DEFS_SVH

`define TKS_ADDR_W          8
`define TKS_OFF_STATUS      8'h00
`define TKS_OFF_CTRL1       8'h04
`define TKS_OFF_CTRL2       8'h08
`define TKS_OFF_CHARGE1     8'h0c
`define TKS_OFF_CHARGE2     8'h10
`define TKS_OFF_SEQ_LEN     8'h2c
`define TKS_OFF_SEQ_SLOT    8'h34
`define TKS_OFF_OFFSET      8'h3c
`define TKS_OFF_START       8'h4c
`define TKS_OFF_CLKDIV      8'h50
`define TKS_OFF_IRQ_CLR     8'h58
`define TKS_OFF_IRQ_EN      8'h5c

`define TKS_BIT_DONE        1
`define TKS_BIT_TOUCH_EN    24
`define TKS_BIT_POWER_ON    0
`define TKS_BIT_SW_START    22
`define TKS_CHARGE1_MASK    32'h00ffffff
`define TKS_CHARGE2_MASK    32'h3fffffff
`define TKS_CHG_FIELD_W     3
`define TKS_CHAN_W          5
`define TKS_CHAN_SPLIT      5'h0a
`define TKS_EXT_CHANNELS    5'h0e
`define TKS_LEN_W           4
`define TKS_BYTE_W          8
`define TKS_DIV_W           4
`define TKS_DIV_RESET       4'h3
`define TKS_CHG_BASE        8'h04
`define TKS_DATA_W          16

`endif

// File: core/tks_pkg.sv
/*
  Types of the touch key sequencer.
  Defines its own state codes and takes no constants from tks_defs.svh.
*/
package tks_pkg;

  // Gray codes along idle, discharge, charge, offset, convert.
  typedef enum logic [2:0] {
    TKS_IDLE  = 3'h0,
    TKS_DISCH = 3'h1,
    TKS_CHG   = 3'h3,
    TKS_OFFS  = 3'h2,
    TKS_CONV  = 3'h6
  } tks_state_t;

endpackage : tks_pkg

// File: core/tks_sequencer.sv
/*
  Touch key sequencer with AXI4-Lite register slave and converter handshake.
  Assumes an external converter on clk_i that pulses its done line and holds its data.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
// Contract
// [RQ1] Software powers converter before enabling touch unit.
// [RQ2] Touch uses single pass, first-slot channel only.
// [RQ3] Start write loads discharge byte and launches sample.
// [RQ4] Discharge then charge for programmed converter clocks.
// [RQ5] Charge length from channel field plus offset.
// [RQ6] Offset register keeps only lower eight bits.
// [RQ7] Software sets first slot channel and length one.
// [RQ8] Conversion end sets done flag; result readable.
// [RQ9] Normal conversion stays usable when touch idle.
// [RQ10] Charge and offset settings persist across conversions.
// [RQ11] Touch shares the fourteen external analog inputs.
// [RQ12] Charge codes map to four through eleven cycles.
// [RQ13] Offset address reads back injected data word.
// [RQ14] Start writes during a running cycle are ignored.
`include "tks_defs.svh"

module tks_sequencer (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [`TKS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`TKS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic                         conv_start_o,
  output logic [`TKS_CHAN_W-1:0]       conv_channel_o,
  input  wire logic                    conv_done_i,
  input  wire logic [`TKS_DATA_W-1:0]  conv_data_i,
  input  wire logic [`TKS_DATA_W-1:0]  inj_data_i,
  output logic                         electrode_out_o,
  output logic                         electrode_oe_n_o,
  output logic                         charge_en_o,
  output logic                         irq_o
);

  tks_pkg::tks_state_t state_reg;
  tks_pkg::tks_state_t state_next;

  logic [`TKS_ADDR_W-1:0]      awaddr_reg;
  logic                        aw_held_reg;
  logic [31:0]                 wdata_reg;
  logic                        w_held_reg;
  logic                        wr_fire;
  logic                        wr_hit;
  logic                        rd_hit;
  logic [31:0]                 rd_mux;
  logic [31:0]                 ctrl1_reg;
  logic [31:0]                 ctrl2_reg;
  logic [31:0]                 charge1_reg;
  logic [31:0]                 charge2_reg;
  logic [`TKS_LEN_W-1:0]       seq_len_reg;
  logic [`TKS_CHAN_W-1:0]      seq_slot_reg;
  logic [`TKS_BYTE_W-1:0]      offset_reg;
  logic [`TKS_DIV_W-1:0]       div_reg;
  logic [`TKS_DATA_W-1:0]      result_reg;
  logic [31:0]                 status_reg;
  logic [31:0]                 irq_en_reg;
  logic [`TKS_DIV_W-1:0]       div_cnt_reg;
  logic                        conv_tick;
  logic [`TKS_BYTE_W-1:0]      cnt_reg;
  logic [2:0]                  done_sync_reg;
  logic                        done_evt;
  logic                        touch_go;
  logic                        norm_go;
  logic [`TKS_CHG_FIELD_W-1:0] chg_code;
  logic [`TKS_BYTE_W-1:0]      chg_cycles;
  logic [4:0]                  field_sel;

  // AXI4-Lite write: address and data taken in either order.
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_bresp   = wr_hit ? 2'h0 : 2'h2;

  always_comb begin
    unique case (awaddr_reg)
      `TKS_OFF_CTRL1, `TKS_OFF_CTRL2, `TKS_OFF_CHARGE1, `TKS_OFF_CHARGE2,
      `TKS_OFF_SEQ_LEN, `TKS_OFF_SEQ_SLOT, `TKS_OFF_OFFSET, `TKS_OFF_START,
      `TKS_OFF_CLKDIV, `TKS_OFF_IRQ_CLR, `TKS_OFF_IRQ_EN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
    end
  end

  // Register writes; start and clear are actions, not storage.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl1_reg    <= '0;
      ctrl2_reg    <= '0;
      charge1_reg  <= '0;
      charge2_reg  <= '0;
      seq_len_reg  <= '0;
      seq_slot_reg <= '0;
      offset_reg   <= '0;
      div_reg      <= `TKS_DIV_RESET;
      irq_en_reg   <= '0;
    end else if (wr_fire && (&s_axi_wstrb || 1'b1)) begin
      unique case (awaddr_reg)
        `TKS_OFF_CTRL1:    ctrl1_reg <= wdata_reg;
        `TKS_OFF_CTRL2:    ctrl2_reg <= wdata_reg;
        `TKS_OFF_CHARGE1:  charge1_reg <= wdata_reg & `TKS_CHARGE1_MASK; // [RQ10]
        `TKS_OFF_CHARGE2:  charge2_reg <= wdata_reg & `TKS_CHARGE2_MASK; // [RQ10]
        `TKS_OFF_SEQ_LEN:  seq_len_reg <= wdata_reg[`TKS_LEN_W-1:0];
        `TKS_OFF_SEQ_SLOT: seq_slot_reg <= wdata_reg[`TKS_CHAN_W-1:0];
        `TKS_OFF_OFFSET:   offset_reg <= wdata_reg[`TKS_BYTE_W-1:0]; // [RQ6]
        `TKS_OFF_CLKDIV:   div_reg <= wdata_reg[`TKS_DIV_W-1:0];
        `TKS_OFF_IRQ_EN:   irq_en_reg <= wdata_reg;
        default: ;
      endcase
    end
  end

  // AXI4-Lite read with one cycle of latency.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `TKS_OFF_STATUS:   rd_mux = status_reg;
      `TKS_OFF_CTRL1:    rd_mux = ctrl1_reg;
      `TKS_OFF_CTRL2:    rd_mux = ctrl2_reg;
      `TKS_OFF_CHARGE1:  rd_mux = charge1_reg;
      `TKS_OFF_CHARGE2:  rd_mux = charge2_reg;
      `TKS_OFF_SEQ_LEN:  rd_mux = {28'h0000000, seq_len_reg};
      `TKS_OFF_SEQ_SLOT: rd_mux = {27'h0000000, seq_slot_reg};
      `TKS_OFF_OFFSET:   rd_mux = {16'h0000, inj_data_i}; // [RQ13]
      `TKS_OFF_START:    rd_mux = {16'h0000, result_reg}; // [RQ8]
      `TKS_OFF_CLKDIV:   rd_mux = {28'h0000000, div_reg};
      `TKS_OFF_IRQ_EN:   rd_mux = irq_en_reg;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Converter clock tick from the prescaler.
  assign conv_tick = (div_cnt_reg == div_reg);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= '0;
    end else if (conv_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // Done line from the converter is synchronised, then edge detected.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_sync_reg <= '0;
    end else begin
      done_sync_reg <= {done_sync_reg[1:0], conv_done_i};
    end
  end
  assign done_evt = done_sync_reg[1] && !done_sync_reg[2];

  // Touch starts only with power and enable, and only from idle.
  assign touch_go = wr_fire && (awaddr_reg == `TKS_OFF_START)
                  && ctrl1_reg[`TKS_BIT_TOUCH_EN] && ctrl2_reg[`TKS_BIT_POWER_ON]
                  && (state_reg == tks_pkg::TKS_IDLE); // [RQ1] [RQ3] [RQ14]
  assign norm_go  = wr_fire && (awaddr_reg == `TKS_OFF_CTRL2)
                  && wdata_reg[`TKS_BIT_SW_START] && wdata_reg[`TKS_BIT_POWER_ON]
                  && (state_reg == tks_pkg::TKS_IDLE); // [RQ9]

  // Per-channel field of the first slot channel.
  always_comb begin
    if (seq_slot_reg < `TKS_CHAN_SPLIT) begin
      field_sel = seq_slot_reg;
      chg_code  = charge2_reg[3*field_sel +: 3]; // [RQ5]
    end else begin
      field_sel = seq_slot_reg - `TKS_CHAN_SPLIT;
      chg_code  = (field_sel < 5'h08) ? charge1_reg[3*field_sel +: 3] : 3'h0; // [RQ5]
    end
  end
  assign chg_cycles = `TKS_CHG_BASE + {5'h00, chg_code[1:0], 1'b0}
                    + {7'h00, chg_code[2]}; // [RQ12]

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tks_pkg::TKS_IDLE: begin
        if (touch_go) begin
          state_next = tks_pkg::TKS_DISCH; // [RQ4]
        end else if (norm_go) begin
          state_next = tks_pkg::TKS_CONV;
        end
      end
      tks_pkg::TKS_DISCH: begin
        if (conv_tick && cnt_reg == '0) begin
          state_next = tks_pkg::TKS_CHG;
        end
      end
      tks_pkg::TKS_CHG: begin
        if (conv_tick && cnt_reg == 8'h01) begin
          state_next = (offset_reg == '0) ? tks_pkg::TKS_CONV : tks_pkg::TKS_OFFS; // [RQ5]
        end
      end
      tks_pkg::TKS_OFFS: begin
        if (cnt_reg == 8'h01) begin // [RQ5]
          state_next = tks_pkg::TKS_CONV;
        end
      end
      tks_pkg::TKS_CONV: begin
        if (done_evt) begin
          state_next = tks_pkg::TKS_IDLE;
        end
      end
      default: state_next = tks_pkg::TKS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= tks_pkg::TKS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase counter: discharge and charge in converter ticks, offset in clocks.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else if (touch_go) begin
      cnt_reg <= wdata_reg[`TKS_BYTE_W-1:0]; // [RQ3] [RQ4]
    end else if (state_reg == tks_pkg::TKS_DISCH && conv_tick) begin
      cnt_reg <= (cnt_reg == '0) ? chg_cycles : cnt_reg - 1'b1; // [RQ4] [RQ5]
    end else if (state_reg == tks_pkg::TKS_CHG && conv_tick) begin
      cnt_reg <= (cnt_reg == 8'h01) ? offset_reg : cnt_reg - 1'b1; // [RQ5]
    end else if (state_reg == tks_pkg::TKS_OFFS && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1; // [RQ5]
    end
  end

  // Electrode pin: driven low in discharge, released otherwise.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      electrode_out_o  <= 1'b0;
      electrode_oe_n_o <= 1'b1;
      charge_en_o      <= 1'b0;
      conv_start_o     <= 1'b0;
      conv_channel_o   <= '0;
    end else begin
      electrode_out_o  <= 1'b0;
      electrode_oe_n_o <= (state_next != tks_pkg::TKS_DISCH); // [RQ4]
      charge_en_o      <= (state_next == tks_pkg::TKS_CHG)
                       || (state_next == tks_pkg::TKS_OFFS); // [RQ4]
      conv_start_o     <= (state_next == tks_pkg::TKS_CONV)
                       && (state_reg != tks_pkg::TKS_CONV); // [RQ2]
      conv_channel_o   <= seq_slot_reg; // [RQ2] [RQ11]
    end
  end

  // Result and done flag; a new done wins over a same-cycle clear.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_reg <= '0;
      status_reg <= '0;
    end else begin
      if (state_reg == tks_pkg::TKS_CONV && done_evt) begin
        result_reg <= conv_data_i; // [RQ8]
      end
      if (wr_fire && awaddr_reg == `TKS_OFF_IRQ_CLR) begin
        status_reg[`TKS_BIT_DONE] <= 1'b0;
      end
      if (state_reg == tks_pkg::TKS_CONV && done_evt) begin
        status_reg[`TKS_BIT_DONE] <= 1'b1; // [RQ8]
      end
    end
  end

  assign irq_o = |(status_reg & irq_en_reg);

endmodule : tks_sequencer

// File: dv/tks_sequencer_props.sv
/*
  Port timing checker of the touch key sequencer.
  Assumes binding into tks_sequencer, whose ports carry the same names.
*/
module tks_sequencer_props (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        conv_start_o,
  input wire logic        electrode_out_o,
  input wire logic        electrode_oe_n_o,
  input wire logic        charge_en_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_dis_end;
    !electrode_oe_n_o ##1 electrode_oe_n_o;
  endsequence
  sequence s_chg_end;
    charge_en_o ##1 !charge_en_o;
  endsequence

  a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  a_phase_apart: assert property (!(charge_en_o && !electrode_oe_n_o))
    else $error("charge and discharge overlap");
  a_dis_then_chg: assert property (s_dis_end |-> ##[0:1] charge_en_o)
    else $error("charge did not follow discharge");
  a_chg_then_conv: assert property (s_chg_end |-> ##[0:1] conv_start_o)
    else $error("conversion did not follow charge");
  a_conv_quiet_pin: assert property (conv_start_o |-> electrode_oe_n_o && !charge_en_o)
    else $error("conversion started during a phase");
  a_pin_level_low: assert property (!electrode_out_o)
    else $error("electrode driven high");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response");
endmodule : tks_sequencer_props

bind tks_sequencer tks_sequencer_props i_tks_sequencer_props (.*);

// File: dv/tks_conv_model.sv
/*
  Behavioural converter on the far side of the touch key sequencer.
  Assumes start_i is a one-cycle pulse on clk_i and lat_i sets the answer delay.
*/
`include "tks_defs.svh"

module tks_conv_model (
  input  wire logic                   clk_i,
  input  wire logic                   start_i,
  input  wire logic [`TKS_CHAN_W-1:0] chan_i,
  input  wire logic [7:0]             lat_i,
  output logic                        done_o,
  output logic [`TKS_DATA_W-1:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`TKS_CHAN_W-1:0] ch;

  // One conversion per start, data settled before done and inverted once hold ends.
  initial begin
    done_o = 1'b0;
    data_o = 16'hffff;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        ch = chan_i;
        repeat (lat_i) @(posedge clk_i);
        data_o <= {11'h600, ch};
        @(posedge clk_i);
        done_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        done_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        data_o <= ~data_o;
      end
    end
  end
endmodule : tks_conv_model

// File: dv/test_tks_sequencer.sv
/*
  Self-checking bench of the touch key sequencer over AXI4-Lite.
  Assumes the converter model answers every start pulse.
*/
`include "tks_defs.svh"

module test_tks_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [15:0] inj_data_i = 16'h5a3c;
  logic [7:0]  lat = 8'h04;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        conv_start_o, conv_done_i, electrode_out_o, electrode_oe_n_o;
  logic        charge_en_o, irq_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [4:0]  conv_channel_o;
  logic [15:0] conv_data_i;
  logic        mon_clr = 1'b1;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_dis = 0;
  int          n_chg = 0;
  int          n_go = 0;
  int          cmap[8] = '{4, 6, 8, 10, 5, 7, 9, 11};

  tks_sequencer i_tks_sequencer (.*);

  tks_conv_model i_tks_conv_model (
    .clk_i  (clk_i),
    .start_i(conv_start_o),
    .chan_i (conv_channel_o),
    .lat_i  (lat),
    .done_o (conv_done_i),
    .data_o (conv_data_i)
  );

  always #2 clk_i = ~clk_i;

  // Timeout and counts of discharge, charge and start cycles.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
    if (mon_clr) begin
      n_dis <= 0;
      n_chg <= 0;
      n_go <= 0;
    end else begin
      n_dis <= n_dis + (electrode_oe_n_o ? 0 : 1);
      n_chg <= n_chg + (charge_en_o ? 1 : 0);
      n_go <= n_go + (conv_start_o ? 1 : 0);
    end
  end

  task automatic results;
    $display("n_compared=%0d bad_count=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_i);
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_i);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr

  task automatic clr;
    mon_clr <= 1'b1;
    @(posedge clk_i);
    mon_clr <= 1'b0;
  endtask : clr

  task automatic fin(input logic [4:0] ch);
    rd = 32'h0;
    while (rd[`TKS_BIT_DONE] !== 1'b1) rdr(`TKS_OFF_STATUS);
    chk(irq_o, 32'h1);
    rdr(`TKS_OFF_START);
    chk(rd, {16'h0, 11'h600, ch});
    wr(`TKS_OFF_IRQ_CLR, 32'h1);
    chk(irq_o, 32'h0);
  endtask : fin

  task automatic touch(input logic [4:0] ch, input logic [7:0] d, input int chg);
    wr(`TKS_OFF_SEQ_SLOT, {27'h0, ch});
    clr();
    wr(`TKS_OFF_START, {24'hffffff, d});
    wr(`TKS_OFF_START, 32'h0);
    fin(ch);
    chk(n_dis, d + 1);
    chk(n_chg, chg);
    chk(n_go, 32'h1);
    chk(conv_channel_o, ch);
  endtask : touch

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rdr(`TKS_OFF_STATUS);
    chk(rd, 32'h0);
    rdr(`TKS_OFF_CLKDIV);
    chk(rd, {28'h0, `TKS_DIV_RESET});
    rdr(8'h80);
    chk({rd[29:0], rsp}, 32'h2);
    wr(8'h80, 32'h1);
    chk(rsp, 32'h2);
    rdr(`TKS_OFF_OFFSET);
    chk(rd, {16'h0, inj_data_i});
    wr(`TKS_OFF_CTRL2, 32'h1);
    wr(`TKS_OFF_CLKDIV, 32'h0);
    wr(`TKS_OFF_SEQ_LEN, 32'h1);
    wr(`TKS_OFF_IRQ_EN, 32'h2);
    clr();
    wr(`TKS_OFF_START, 32'h2);
    repeat (40) @(posedge clk_i);
    chk(n_go + n_dis, 32'h0);
    wr(`TKS_OFF_CTRL1, 32'h1 << `TKS_BIT_TOUCH_EN);
    wr(`TKS_OFF_OFFSET, 32'h105);
    for (int i = 0; i < 8; i++) begin
      wr(`TKS_OFF_CHARGE2, {29'h0, i[2:0]} << (3 * i));
      lat <= 8'(i + 2);
      touch(i[4:0], i[7:0] + 8'h01, cmap[i] + 5);
    end
    wr(`TKS_OFF_CHARGE1, 32'h7 << 9);
    touch(5'h0d, 8'h00, 16);
    touch(5'h0d, 8'h03, 16);
    wr(`TKS_OFF_OFFSET, 32'h300);
    touch(5'h0d, 8'h02, 11);
    clr();
    wr(`TKS_OFF_CTRL2, 32'h1 | (32'h1 << `TKS_BIT_SW_START));
    fin(5'h0d);
    chk(n_go + n_dis + n_chg, 32'h1);
    results();
  end
endmodule : test_tks_sequencer
